// ==== verilog/fpe_pkg.sv ====
// Constants shared by the flash program/erase command sequencer.
// Assumes a 32-bit APB register port and a 16-bit word array port.
package fpe_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_STAT = 8'h00;
   localparam logic [7:0] OFS_IDX = 8'h04;
   localparam logic [7:0] OFS_PARAM = 8'h08;
   localparam logic [7:0] OFS_PROT = 8'h0c;
   localparam logic [7:0] OFS_SEC = 8'h10;
   // Status register bit positions
   localparam int STB_COMPLETE = 7;
   localparam int STB_ACC = 5;
   localparam int STB_PV = 4;
   localparam int STB_VER = 1;
   localparam int STB_NC = 0;
   // Protection register fields
   localparam int PRB_FEN = 16;
   localparam int PRB_EEN = 17;
   localparam logic [17:0] PROT_RST = 18'h00000;
   // Command opcodes
   localparam logic [7:0] OP_PGM = 8'h06;
   localparam logic [7:0] OP_ONCE = 8'h07;
   localparam logic [7:0] OP_ERA = 8'h08;
   // Parameter word indices
   localparam logic [2:0] IX_CMD = 3'h0;
   localparam logic [2:0] IX_ADDR = 3'h1;
   localparam logic [2:0] IX_DATA = 3'h2;
   localparam logic [2:0] IX_ONE_LW = 3'h3;
   localparam logic [2:0] IX_TWO_LW = 3'h5;
   localparam logic [2:0] IX_LAST = 3'h5;
   // Ranges and values
   localparam logic [15:0] ONCE_LAST = 16'h0007;
   localparam logic [15:0] ERASED_WORD = 16'hffff;
   localparam logic [23:0] SPAN_ONE = 24'h000003;
   localparam logic [23:0] SPAN_TWO = 24'h000007;
   localparam logic [1:0] KMAX_ONE = 2'h1;
   localparam logic [1:0] KMAX_TWO = 2'h3;
   localparam int GA_BLK = 23;
   typedef enum logic [1:0] {
      AOP_RD = 2'b00, AOP_WR = 2'b01, AOP_ERA = 2'b10, AOP_BLK = 2'b11
   } fpe_aop_e;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_CHECK = 3'b001, S_PRE = 3'b010, S_PROG = 3'b011,
      S_VER = 3'b100, S_ERA = 3'b101, S_BLANK = 3'b110, S_DONE = 3'b111
   } fpe_state_e;
endpackage : fpe_pkg

// ==== verilog/fpe_arr_if.sv ====
// Request/answer link between the sequencer and its array engine.
// Both ends run on pclk; req is a one-cycle pulse, done likewise.
`timescale 1ns/100ps
interface fpe_arr_if;
   import fpe_pkg::*;
   logic req;
   fpe_aop_e op;
   logic info;
   logic [23:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic done;
   logic err;
   logic nc;
   modport seq (output req, op, info, addr, wdata, input rdata, done, err, nc);
   modport eng (input req, op, info, addr, wdata, output rdata, done, err, nc);
endinterface : fpe_arr_if

// ==== verilog/fpe_arr_engine.sv ====
// Array engine: turns one sequencer request into one array handshake.
// Assumes the array shares pclk and pulses arr_ack once per request.
`timescale 1ns/100ps
module fpe_arr_engine
   import fpe_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   fpe_arr_if.eng seq,
   output logic arr_req,
   output logic [1:0] arr_op,
   output logic arr_info,
   output logic [23:0] arr_addr,
   output logic [15:0] arr_wdata,
   input wire logic [15:0] arr_rdata,
   input wire logic arr_ack,
   input wire logic arr_err,
   input wire logic arr_nc
);
   // Request held until the array acknowledges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arr_req <= 1'b0;
         arr_op <= 2'b00;
         arr_info <= 1'b0;
         arr_addr <= 24'h000000;
         arr_wdata <= 16'h0000;
      end else if (!arr_req && seq.req) begin
         arr_req <= 1'b1;
         arr_op <= seq.op;
         arr_info <= seq.info;
         arr_addr <= seq.addr;
         arr_wdata <= seq.wdata;
      end else if (arr_req && arr_ack) begin
         arr_req <= 1'b0;
      end
   end

   // Answer captured on the acknowledge, done pulses one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq.done <= 1'b0;
         seq.rdata <= 16'h0000;
         seq.err <= 1'b0;
         seq.nc <= 1'b0;
      end else begin
         seq.done <= arr_req && arr_ack;
         if (arr_req && arr_ack) begin
            seq.rdata <= arr_rdata;
            seq.err <= arr_err;
            seq.nc <= arr_nc;
         end
      end
   end
endmodule : fpe_arr_engine

// ==== verilog/fpe_seq.sv ====
// Command sequencer for program-flash, program-once and erase-all.
// Assumes an APB master on pclk and an array that answers each word op.
//
// How it works
// - Program: opcode 06, address, two or four data words
// - Program writes, reads back, then sets complete
// - Program index must be 3 or 5
// - Misaligned program address gives access error
// - Words past block end give access error
// - Protected target: protection flag, no program
// - Verify errors set verify, noncorrectable flags
// - Command refused in locked mode: access error
// - Once: opcode 07, phrase index, four words
// - Phrase index above 7 gives access error
// - Once checks erased, programs, verifies
// - Once index must be 5
// - Programmed phrase refused; all-ones phrase allowed
// - Flash reads invalid while once runs
// - Opcode 08 erases all then verifies
// - Erase-all index must be 0
// - Blank verify passes: security released
// - Any protection on: erase-all refused
// - Address bit 23 picks flash or EEPROM
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module fpe_seq
   import fpe_pkg::*;
#(
   parameter logic [23:0] FLASH_BYTES = 24'h004000,
   parameter logic [23:0] EE_BYTES = 24'h000100
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mode_lock,
   output logic secured,
   output logic flash_read_invalid,
   output logic arr_req,
   output logic [1:0] arr_op,
   output logic arr_info,
   output logic [23:0] arr_addr,
   output logic [15:0] arr_wdata,
   input wire logic [15:0] arr_rdata,
   input wire logic arr_ack,
   input wire logic arr_err,
   input wire logic arr_nc
);
   fpe_arr_if c ();
   fpe_state_e state_r;
   logic command_complete_flag_r, access_error_flag_r, protection_violation_flag_r;
   logic ver_r, nc_r, secured_r;
   logic [2:0] idx_r;
   logic [15:0] buf_r [0:5];
   logic [17:0] prot_r;
   logic [1:0] k_r, kmax_r;
   logic pend_r, once_r, lock_s1_r, lock_s2_r;
   logic wr, mapped, launch, clr_acc, clr_pv;
   logic acc_c, pv_c, arr_st;
   logic [7:0] cmd;
   logic [23:0] gaddr, last_c, bsize_c;
   logic [2:0] widx_c;
   logic [31:0] rd_nxt;

   // Zero-wait slave; unmapped offsets answer with an error
   assign wr = psel && penable && pwrite;
   assign mapped = (paddr == OFS_STAT) || (paddr == OFS_IDX) || (paddr == OFS_PARAM)
      || (paddr == OFS_PROT) || (paddr == OFS_SEC);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Busy writes are dropped so a running erase cannot be disturbed
   assign launch = wr && (paddr == OFS_STAT) && pwdata[STB_COMPLETE]
      && command_complete_flag_r && !access_error_flag_r && !protection_violation_flag_r;
   assign clr_acc = wr && (paddr == OFS_STAT) && pwdata[STB_ACC] && command_complete_flag_r;
   assign clr_pv = wr && (paddr == OFS_STAT) && pwdata[STB_PV] && command_complete_flag_r;

   // Mode pin comes from outside the clock domain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_s1_r <= 1'b0;
         lock_s2_r <= 1'b0;
      end else begin
         lock_s1_r <= mode_lock;
         lock_s2_r <= lock_s1_r;
      end
   end

   // Index and parameter buffer, writable only while idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_r <= IX_CMD;
         for (int i = 0; i <= int'(IX_LAST); i++) buf_r[i] <= 16'h0000;
      end else if (wr && command_complete_flag_r) begin
         if (paddr == OFS_IDX) idx_r <= pwdata[2:0];
         if (paddr == OFS_PARAM && idx_r <= IX_LAST) buf_r[idx_r] <= pwdata[15:0];
      end
   end

   // Protection setup: start of protected flash and enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prot_r <= PROT_RST;
      else if (wr && command_complete_flag_r && paddr == OFS_PROT) prot_r <= pwdata[17:0];
   end

   // Fields of the loaded command
   // opcode high byte, address split over two words
   assign cmd = buf_r[IX_CMD][15:8];
   assign gaddr = {buf_r[IX_CMD][7:0], buf_r[IX_ADDR]};
   // block select picks the size limit
   assign bsize_c = gaddr[GA_BLK] ? EE_BYTES : FLASH_BYTES;
   assign last_c = {1'b0, gaddr[22:0]} + ((idx_r == IX_TWO_LW) ? SPAN_TWO : SPAN_ONE);
   assign widx_c = IX_DATA + {1'b0, k_r};

   // Launch checks, all evaluated in the check cycle
   always_comb begin
      acc_c = 1'b0;
      pv_c = 1'b0;
      unique case (cmd)
         OP_PGM: begin
            acc_c = (idx_r != IX_ONE_LW) && (idx_r != IX_TWO_LW);
            if (gaddr[1:0] != 2'b00) acc_c = 1'b1;
            if (last_c >= bsize_c) acc_c = 1'b1;
            // flash above the boundary, or all EEPROM
            pv_c = gaddr[GA_BLK] ? prot_r[PRB_EEN]
               : (prot_r[PRB_FEN] && last_c[15:0] >= prot_r[15:0]);
         end
         OP_ONCE: begin
            acc_c = (idx_r != IX_TWO_LW);
            if (buf_r[IX_ADDR] > ONCE_LAST) acc_c = 1'b1;
         end
         OP_ERA: begin
            acc_c = (idx_r != IX_CMD);
            pv_c = prot_r[PRB_FEN] || prot_r[PRB_EEN];
         end
         default: acc_c = 1'b1;
      endcase
      if (lock_s2_r) acc_c = 1'b1;
   end

   // Array request, one per word step
   assign arr_st = (state_r == S_PRE) || (state_r == S_PROG) || (state_r == S_VER)
      || (state_r == S_ERA) || (state_r == S_BLANK);
   assign c.req = arr_st && !pend_r;
   assign c.info = once_r;
   assign c.wdata = buf_r[widx_c];
   always_comb begin
      unique case (state_r)
         S_PROG: c.op = AOP_WR;
         S_ERA: c.op = AOP_ERA;
         S_BLANK: c.op = AOP_BLK;
         default: c.op = AOP_RD;
      endcase
      // phrase index picks the phrase, word counter the slot
      if (once_r) c.addr = {18'h00000, buf_r[IX_ADDR][2:0], k_r, 1'b0};
      else c.addr = gaddr + {21'h000000, k_r, 1'b0};
   end

   // Sequencer state, word counter and outstanding request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= S_IDLE;
         k_r <= 2'b00;
         kmax_r <= 2'b00;
         pend_r <= 1'b0;
         once_r <= 1'b0;
      end else begin
         if (c.req) pend_r <= 1'b1;
         else if (c.done) pend_r <= 1'b0;
         unique case (state_r)
            S_IDLE: if (launch) state_r <= S_CHECK;
            S_CHECK: begin
               k_r <= 2'b00;
               kmax_r <= (cmd == OP_PGM && idx_r == IX_ONE_LW) ? KMAX_ONE : KMAX_TWO;
               // a failed check skips the array
               if (acc_c || pv_c) state_r <= S_DONE;
               else if (cmd == OP_PGM) state_r <= S_PROG;
               else if (cmd == OP_ONCE) state_r <= S_PRE;
               else state_r <= S_ERA;
               once_r <= !acc_c && !pv_c && cmd == OP_ONCE;
            end
            S_PRE: if (c.done) begin
               // anything but all ones is already programmed
               if (c.rdata != ERASED_WORD) state_r <= S_DONE;
               else if (k_r == kmax_r) state_r <= S_PROG;
               k_r <= (k_r == kmax_r) ? 2'b00 : k_r + 2'b01;
            end
            // write every word, then read all back
            S_PROG: if (c.done) begin
               if (k_r == kmax_r) state_r <= S_VER;
               k_r <= (k_r == kmax_r) ? 2'b00 : k_r + 2'b01;
            end
            S_VER: if (c.done) begin
               if (k_r == kmax_r) state_r <= S_DONE;
               k_r <= k_r + 2'b01;
            end
            S_ERA: if (c.done) state_r <= S_BLANK;
            S_BLANK: if (c.done) state_r <= S_DONE;
            S_DONE: begin
               state_r <= S_IDLE;
               once_r <= 1'b0;
            end
         endcase
      end
   end

   // Complete flag: cleared by launch, set when the sequence ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) command_complete_flag_r <= 1'b1;
      else if (launch) command_complete_flag_r <= 1'b0;
      else if (state_r == S_DONE) command_complete_flag_r <= 1'b1;
   end

   // Access error; a hardware set beats a software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) access_error_flag_r <= 1'b0;
      else if ((state_r == S_CHECK && acc_c)
         || (state_r == S_PRE && c.done && c.rdata != ERASED_WORD))
         access_error_flag_r <= 1'b1;
      else if (clr_acc) access_error_flag_r <= 1'b0;
   end

   // Protection violation, same priority
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) protection_violation_flag_r <= 1'b0;
      else if (state_r == S_CHECK && pv_c) protection_violation_flag_r <= 1'b1;
      else if (clr_pv) protection_violation_flag_r <= 1'b0;
   end

   // Verify result flags, cleared at each launch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ver_r <= 1'b0;
         nc_r <= 1'b0;
      end else if (launch) begin
         ver_r <= 1'b0;
         nc_r <= 1'b0;
      end else if (c.done && (state_r == S_VER || state_r == S_BLANK)) begin
         // mismatch or read error; blank failure reports through err
         if (c.err || c.nc || (state_r == S_VER && c.rdata != buf_r[widx_c])) ver_r <= 1'b1;
         if (c.nc) nc_r <= 1'b1;
      end
   end

   // Security: only a clean blank check releases it, reset restores it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) secured_r <= 1'b1;
      else if (state_r == S_BLANK && c.done && !c.err && !c.nc) secured_r <= 1'b0;
   end
   assign secured = secured_r;

   // flash reads flagged invalid during program-once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) flash_read_invalid <= 1'b0;
      else flash_read_invalid <= (state_r == S_CHECK && !acc_c && cmd == OP_ONCE)
         || (once_r && state_r != S_DONE);
   end

   // Read data latched in the setup cycle
   always_comb begin
      rd_nxt = 32'h00000000;
      unique case (paddr)
         OFS_STAT: begin
            rd_nxt[STB_COMPLETE] = command_complete_flag_r;
            rd_nxt[STB_ACC] = access_error_flag_r;
            rd_nxt[STB_PV] = protection_violation_flag_r;
            rd_nxt[STB_VER] = ver_r;
            rd_nxt[STB_NC] = nc_r;
         end
         OFS_IDX: rd_nxt[2:0] = idx_r;
         OFS_PARAM: if (idx_r <= IX_LAST) rd_nxt[15:0] = buf_r[idx_r];
         OFS_PROT: rd_nxt[17:0] = prot_r;
         OFS_SEC: rd_nxt[0] = secured_r;
         default: rd_nxt = 32'h00000000;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h00000000;
      else if (psel && !penable) prdata <= rd_nxt;
   end

   fpe_arr_engine u_eng (
      .pclk(pclk),
      .presetn(presetn),
      .seq(c.eng),
      .arr_req(arr_req),
      .arr_op(arr_op),
      .arr_info(arr_info),
      .arr_addr(arr_addr),
      .arr_wdata(arr_wdata),
      .arr_rdata(arr_rdata),
      .arr_ack(arr_ack),
      .arr_err(arr_err),
      .arr_nc(arr_nc)
   );

   // Checks on the sequencer
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic chk_w;
   assign chk_w = (state_r == S_CHECK);
   sequence s_reject;
      chk_w && (acc_c || pv_c);
   endsequence
   sequence s_finish;
      state_r == S_DONE ##1 command_complete_flag_r && state_r == S_IDLE;
   endsequence

   AST_PGM_IDX: assert property (chk_w && cmd == OP_PGM && idx_r != 3'h3
      && idx_r != 3'h5 |=> access_error_flag_r) else $error("bad program index not flagged");
   AST_PGM_ALIGN: assert property (chk_w && cmd == OP_PGM && gaddr[1:0] != 2'b00
      |=> access_error_flag_r && !arr_req) else $error("misaligned program not flagged");
   AST_PROT_SKIP: assert property (chk_w && cmd == OP_PGM && pv_c
      |=> protection_violation_flag_r ##1 !arr_req)
      else $error("protected program not refused");
   AST_ONCE_RANGE: assert property (chk_w && cmd == OP_ONCE
      && buf_r[1] > 16'h0007 |=> access_error_flag_r) else $error("phrase index not checked");
   AST_ONCE_IDX: assert property (chk_w && cmd == OP_ONCE && idx_r != 3'h5
      |=> access_error_flag_r) else $error("once index not checked");
   AST_ERA_IDX: assert property (chk_w && cmd == OP_ERA && idx_r != 3'h0
      |=> access_error_flag_r) else $error("erase index not checked");
   AST_ERA_PROT: assert property (chk_w && cmd == OP_ERA
      && (prot_r[16] || prot_r[17]) |=> protection_violation_flag_r)
      else $error("erase protection missed");
   AST_MODE: assert property (chk_w && lock_s2_r |=> access_error_flag_r
      && state_r == S_DONE) else $error("locked mode not refused");
   AST_SKIP: assert property (s_reject |=> s_finish)
      else $error("rejected command did not complete at once");
   AST_UNSEC: assert property ($fell(secured_r) |-> $past(state_r) == S_BLANK
      && $past(c.done) && !$past(c.err)) else $error("security released without blank");
   AST_BUSY: assert property (state_r != S_IDLE && state_r != S_DONE
      |-> !command_complete_flag_r) else $error("complete flag high while busy");
   AST_RD_INV: assert property (once_r && state_r == S_PROG
      |-> flash_read_invalid) else $error("reads valid during program-once");
endmodule : fpe_seq

// ==== sim/fpe_tb_top.sv ====
// Self-checking bench for the flash program/erase command sequencer.
// Assumes fpe_seq answers APB with zero wait states; the bench plays the array.
`timescale 1ns/100ps
module fpe_tb_top;
   import fpe_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd, st;
   logic pready, pslverr, secured, fri, arr_req, arr_info, err_s;
   logic mode_lock = 1'b0;
   logic [1:0] arr_op;
   logic [23:0] arr_addr;
   logic [15:0] arr_wdata;
   logic [15:0] arr_rdata = 16'h0;
   logic arr_ack = 1'b0;
   logic arr_err = 1'b0;
   logic arr_nc = 1'b0;
   logic inj_err = 1'b0;
   logic inj_nc = 1'b0;
   logic seen_fri = 1'b0;
   logic req_d = 1'b0;
   logic [24:0] key;
   logic [15:0] mem [logic [24:0]];
   logic [1:0] ops [$];
   int n_errors = 0;
   int compares = 0;
   int n_req = 0;
   int wcnt = 0;

   always #50 pclk = ~pclk;

   fpe_seq #(.FLASH_BYTES(24'h004000), .EE_BYTES(24'h000100)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mode_lock(mode_lock), .secured(secured), .flash_read_invalid(fri),
      .arr_req(arr_req), .arr_op(arr_op), .arr_info(arr_info), .arr_addr(arr_addr),
      .arr_wdata(arr_wdata), .arr_rdata(arr_rdata), .arr_ack(arr_ack), .arr_err(arr_err),
      .arr_nc(arr_nc));

   assign key = {arr_info, arr_addr};

   // Array stand-in: three wait cycles per op; answer lines toggle when idle
   always @(posedge pclk) begin
      arr_ack <= 1'b0;
      arr_rdata <= ~arr_rdata;
      arr_err <= ~arr_err;
      arr_nc <= ~arr_nc;
      if (arr_req && !arr_ack) begin
         if (wcnt == 2) begin
            wcnt <= 0;
            arr_ack <= 1'b1;
            arr_err <= inj_err;
            arr_nc <= inj_nc;
            ops.push_back(arr_op);
            if (arr_op == 2'b00) arr_rdata <= mem.exists(key) ? mem[key] : 16'hffff;
            if (arr_op == 2'b01) mem[key] = arr_wdata;
         end else begin
            wcnt <= wcnt + 1;
         end
      end
   end

   // Request counter and read-invalid watch
   always @(posedge pclk) begin
      req_d <= arr_req;
      if (arr_req && !req_d) n_req++;
      if (fri === 1'b1) seen_fri <= 1'b1;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   function automatic logic [31:0] rdm(input logic [24:0] k);
      return mem.exists(k) ? {16'h0, mem[k]} : 32'hxxxxxxxx;
   endfunction : rdm

   // One APB transfer; pready sampled at each access edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      if (t >= 50) n_errors++;
      rd = prdata;
      err_s = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic par(input logic [2:0] i, input logic [15:0] v);
      apb(1'b1, OFS_IDX, {29'h0, i});
      apb(1'b1, OFS_PARAM, {16'h0, v});
   endtask : par

   // Load buffer, launch, poll until complete; status left in st
   task automatic run(input logic [7:0] op, input logic [23:0] a, input int n,
                      input logic [2:0] ix, input logic [63:0] d);
      int t;
      par(IX_CMD, {op, a[23:16]});
      par(IX_ADDR, a[15:0]);
      for (int i = 0; i < n; i++) par(3'(i + 2), d[16*i +: 16]);
      apb(1'b1, OFS_IDX, {29'h0, ix});
      seen_fri = 1'b0;
      n_req = 0;
      ops.delete();
      apb(1'b1, OFS_STAT, 32'h80);
      t = 0;
      do begin
         apb(1'b0, OFS_STAT, 32'h0);
         t++;
      end while (rd[7] !== 1'b1 && t < 200);
      if (t >= 200) n_errors++;
      st = rd;
   endtask : run

   // Program case: status, no array traffic on refusal, then clear flags
   task automatic pcase(input logic [23:0] a, input logic [2:0] ix, input logic [31:0] exp);
      run(OP_PGM, a, 4, ix, 64'h8888_7777_6666_5555);
      chk("pgm status", st, exp);
      if (exp[5] || exp[4]) chk("pgm requests", n_req, 0);
      apb(1'b1, OFS_STAT, 32'h30);
   endtask : pcase

   task automatic t_reset;
      apb(1'b0, OFS_STAT, 32'h0);
      chk("stat reset", rd, 32'h80);
      apb(1'b0, OFS_PROT, 32'h0);
      chk("prot reset", rd, 32'h0);
      apb(1'b0, OFS_SEC, 32'h0);
      chk("sec reset", rd, 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped err", {31'h0, err_s}, 32'h1);
      chk("unmapped data", rd, 32'h0);
   endtask : t_reset

   task automatic t_prog;
      run(OP_PGM, 24'h000100, 4, IX_TWO_LW, 64'h4444_3333_2222_1111);
      chk("pgm2 status", st, 32'h80);
      chk("pgm2 word0", rdm({1'b0, 24'h000100}), 32'h1111);
      chk("pgm2 word3", rdm({1'b0, 24'h000106}), 32'h4444);
      chk("pgm2 ops", ops.size(), 8);
      chk("pgm read ok", {31'h0, seen_fri}, 32'h0);
      run(OP_PGM, 24'h000200, 2, IX_ONE_LW, 64'h0000_0000_2222_1111);
      chk("pgm1 word1", rdm({1'b0, 24'h000202}), 32'h2222);
      chk("pgm1 stop", {31'h0, mem.exists({1'b0, 24'h000204})}, 32'h0);
      run(OP_PGM, 24'h800010, 2, IX_ONE_LW, 64'h0000_0000_bbbb_aaaa);
      chk("ee word1", rdm({1'b0, 24'h800012}), 32'hbbbb);
   endtask : t_prog

   task automatic t_perr;
      pcase(24'h000300, 3'h4, 32'ha0);
      pcase(24'h000302, IX_TWO_LW, 32'ha0);
      pcase(24'h003ffc, IX_TWO_LW, 32'ha0);
      pcase(24'h003ff8, IX_TWO_LW, 32'h80);
      apb(1'b1, OFS_PROT, 32'h12000);
      pcase(24'h002000, IX_TWO_LW, 32'h90);
      pcase(24'h001ff8, IX_TWO_LW, 32'h80);
      apb(1'b1, OFS_PROT, 32'h0);
      mode_lock <= 1'b1;
      repeat (3) @(posedge pclk);
      pcase(24'h000400, IX_TWO_LW, 32'ha0);
      mode_lock <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask : t_perr

   task automatic t_once;
      // first write to an erased phrase
      run(OP_ONCE, 24'h000002, 4, IX_TWO_LW, 64'h0d0c_0b0a_0908_0706);
      chk("once status", st, 32'h80);
      chk("once word3", rdm({1'b1, 24'h000016}), 32'h0d0c);
      chk("once ops", ops.size(), 12);
      chk("once read bad", {31'h0, seen_fri}, 32'h1);
      run(OP_ONCE, 24'h000002, 4, IX_TWO_LW, 64'h1111_1111_1111_1111);
      chk("once again", st, 32'ha0);
      chk("once kept", rdm({1'b1, 24'h000010}), 32'h0706);
      apb(1'b1, OFS_STAT, 32'h30);
      run(OP_ONCE, 24'h000003, 4, IX_TWO_LW, 64'hffff_ffff_ffff_ffff);
      run(OP_ONCE, 24'h000003, 4, IX_TWO_LW, 64'h5555_5555_5555_5555);
      chk("once ones", st, 32'h80);
      run(OP_ONCE, 24'h000008, 4, IX_TWO_LW, 64'h0);
      chk("once range", st, 32'ha0);
      apb(1'b1, OFS_STAT, 32'h30);
      run(OP_ONCE, 24'h000007, 3, 3'h4, 64'h0);
      chk("once index", st, 32'ha0);
      apb(1'b1, OFS_STAT, 32'h30);
      run(OP_ONCE, 24'h000007, 4, IX_TWO_LW, 64'h0);
      chk("once last", st, 32'h80);
   endtask : t_once

   task automatic t_erase;
      run(OP_ERA, 24'h0, 0, 3'h1, 64'h0);
      chk("era index", st, 32'ha0);
      apb(1'b1, OFS_STAT, 32'h30);
      apb(1'b1, OFS_PROT, 32'h20000);
      run(OP_ERA, 24'h0, 0, IX_CMD, 64'h0);
      chk("era prot", st, 32'h90);
      apb(1'b1, OFS_STAT, 32'h30);
      apb(1'b1, OFS_PROT, 32'h0);
      inj_err = 1'b1;
      run(OP_ERA, 24'h0, 0, IX_CMD, 64'h0);
      inj_err = 1'b0;
      chk("era fail", st & 32'hb3, 32'h82);
      chk("era kept", {31'h0, secured}, 32'h1);
      run(OP_ERA, 24'h0, 0, IX_CMD, 64'h0);
      chk("era status", st & 32'hb0, 32'h80);
      chk("era ops", ops.size(), 2);
      chk("era op0", {30'h0, ops[0]}, 32'h2);
      chk("era op1", {30'h0, ops[1]}, 32'h3);
      chk("unsecured", {31'h0, secured}, 32'h0);
      apb(1'b0, OFS_SEC, 32'h0);
      chk("sec reg", rd, 32'h0);
      // Unknown opcode refused without array traffic
      run(8'h05, 24'h0, 0, IX_CMD, 64'h0);
      chk("bad opcode", st, 32'ha0);
      chk("bad op requests", n_req, 0);
      apb(1'b1, OFS_STAT, 32'h30);
   endtask : t_erase

   task automatic t_verify;
      inj_nc = 1'b1;
      run(OP_PGM, 24'h000500, 4, IX_TWO_LW, 64'h1);
      inj_nc = 1'b0;
      chk("pgm nc", st & 32'hb3, 32'h83);
   endtask : t_verify

   task automatic end_of_test;
      if (n_errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   // Watchdog: runs take a few thousand cycles, so 50000 is ample
   initial begin
      #5000000;
      n_errors++;
      end_of_test();
   end

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_prog();
      t_perr();
      t_once();
      t_erase();
      t_verify();
      end_of_test();
   end
endmodule : fpe_tb_top
